/* File: rtl/gpio_pin_function_cfg.svh */
/*
 * Constants for the GPIO pin function configuration block: select codes,
 * reset values per port variant, field widths.
 * Assumes it is included by bare name from rtl/.
 */
`ifndef GPIO_PIN_FUNCTION_CFG_SVH
`define GPIO_PIN_FUNCTION_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PORT_WIDTH 8

// ----------------------------------------------------------------------
// Subregister select codes
// ----------------------------------------------------------------------
`define SEL_NONE 8'h00
`define SEL_DIRECTION 8'h01
`define SEL_ALT_ENABLE 8'h02
`define SEL_OPEN_DRAIN 8'h03
`define SEL_STRONG_DRIVE 8'h04
`define SEL_WAKE_SOURCE 8'h05
`define SEL_FUNC_LOW 8'h07
`define SEL_FUNC_HIGH 8'h08

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SELECT 8'h00
`define RST_ALT_ABC 8'h00
`define RST_ALT_D 8'h01
`define RST_ALT_SMALL_A 8'h04
`define RST_OD_ABC 8'h00
`define RST_OD_D 8'h01
`define RST_STRONG 8'h00
`define RST_WAKE 8'h00

`endif

/* File: rtl/gpio_pin_function_pkg.sv */
/*
 * Types for the GPIO pin function configuration block.
 * Assumes nothing of its surroundings.
 */
package gpio_pin_function_pkg;

    // Which port variant an instance implements; sets reset values
    typedef enum logic [1:0] {
        PORT_ABC,
        PORT_D,
        PORT_A_SMALL
    } port_variant_e;

    typedef logic [7:0] port_byte_t;

endpackage : gpio_pin_function_pkg

/* File: rtl/gpio_pin_function_config.sv */
/*
 * One GPIO port's configuration subregisters (alternate function enable,
 * open-drain, strong drive, wake source) behind a select/window pair,
 * plus the pin-side muxing they steer.
 * Assumes a synchronous CPU register port on core_clk, direction and
 * function select bits supplied by neighbouring logic, and pads outside.
 */
`timescale 1ns/1ps
`include "gpio_pin_function_cfg.svh"

// Function
// - Select code 02H exposes the alternate function enable subregister.
// - Alternate enable 0 makes the pin plain GPIO using its direction bit.
// - Alternate enable 1 hands the pin to the selected alternate function.
// - Two function select bits pick one of four alternate functions.
// - Alternate enable resets to 00H, 01H port D, 04H small port A.
// - Select code 03H exposes the open-drain subregister.
// - Open-drain bit 1 removes high-side drive; pin only pulls low.
// - Open-drain bit 0 gives push-pull unless alternate function overrides.
// - Open-drain applies to alternate function pins too.
// - Open-drain resets to 00H, or 01H for port D.
// - Select code 04H exposes the strong drive subregister.
// - Strong drive bit picks high or standard current, GPIO or alternate.
// - Select code 05H exposes the wake source subregister.
// - In stop mode, any edge on an enabled wake pin starts recovery.
// - Window accesses reach the subregister named by the current select.
// - Select 00H, its reset value, reaches no subregister.
// - GPIO direction 0 drives output data; 1 tristates and samples.
module gpio_pin_function_config #(
    parameter gpio_pin_function_pkg::port_variant_e VARIANT =
        gpio_pin_function_pkg::PORT_ABC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic select_wr,
    input wire logic window_wr,
    input wire logic [7:0] wr_data,
    output logic [7:0] port_subreg_select,
    output logic [7:0] port_subreg_window,
    input wire logic [7:0] pin_direction_bit,
    input wire logic [7:0] function_select_low,
    input wire logic [7:0] function_select_high,
    input wire logic [7:0] out_data,
    input wire logic [31:0] alt_out,
    input wire logic [31:0] alt_oe,
    input wire logic stop_mode,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_strong,
    output logic [7:0] in_data,
    output logic [7:0] alt_in,
    output logic stop_recovery
);

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    logic [7:0] pad_meta;
    logic [7:0] pad_sync;
    logic [7:0] pad_prev;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_meta <= 8'h00;
            pad_sync <= 8'h00;
        end else begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    // Last synchronised level, for edge detection only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_prev <= 8'h00;
        end else begin
            pad_prev <= pad_sync;
        end
    end

    // ------------------------------------------------------------------
    // Subregisters
    // ------------------------------------------------------------------
    logic [7:0] alt_function_enable_reg;
    logic [7:0] open_drain_reg;
    logic [7:0] strong_drive_reg;
    logic [7:0] wake_source_reg;
    logic [7:0] alt_reset;
    logic [7:0] od_reset;

    assign alt_reset =
        (VARIANT == gpio_pin_function_pkg::PORT_D) ? `RST_ALT_D :
        (VARIANT == gpio_pin_function_pkg::PORT_A_SMALL) ? `RST_ALT_SMALL_A :
        `RST_ALT_ABC;
    assign od_reset = (VARIANT == gpio_pin_function_pkg::PORT_D) ?
        `RST_OD_D : `RST_OD_ABC;

    // Decoded window write strobe for one select code
    function automatic logic hit(input logic wr, input logic [7:0] sel,
                                 input logic [7:0] code);
        hit = wr && (sel == code);
    endfunction : hit

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_subreg_select <= `RST_SELECT;
        end else if (select_wr) begin
            port_subreg_select <= wr_data;
        end
    end

    // Variant reset values land on the first cycle after release, so
    // every asynchronous reset branch stays constant-only
    logic rst_n_d;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_n_d <= 1'b0;
        end else begin
            rst_n_d <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Window write strobes
    // ------------------------------------------------------------------
    // window writes follow the current select; full byte
    // select 00H and unlisted codes raise no strobe
    logic alt_wr;
    logic od_wr;
    logic strong_wr;
    logic wake_wr;
    assign alt_wr = hit(window_wr, port_subreg_select, `SEL_ALT_ENABLE);
    assign od_wr = hit(window_wr, port_subreg_select, `SEL_OPEN_DRAIN);
    assign strong_wr = hit(window_wr, port_subreg_select, `SEL_STRONG_DRIVE);
    assign wake_wr = hit(window_wr, port_subreg_select, `SEL_WAKE_SOURCE);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_function_enable_reg <= `RST_ALT_ABC;
        end else if (!rst_n_d) begin
            alt_function_enable_reg <= alt_reset;
        end else if (alt_wr) begin
            alt_function_enable_reg <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            open_drain_reg <= `RST_OD_ABC;
        end else if (!rst_n_d) begin
            open_drain_reg <= od_reset;
        end else if (od_wr) begin
            open_drain_reg <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strong_drive_reg <= `RST_STRONG;
        end else if (strong_wr) begin
            strong_drive_reg <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_source_reg <= `RST_WAKE;
        end else if (wake_wr) begin
            wake_source_reg <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Read-back; neighbour subregisters are read from their own ports
    // ------------------------------------------------------------------
    logic [7:0] next_window;
    always_comb begin
        case (port_subreg_select)
            `SEL_DIRECTION: next_window = pin_direction_bit;
            `SEL_ALT_ENABLE: next_window = alt_function_enable_reg;
            `SEL_OPEN_DRAIN: next_window = open_drain_reg;
            `SEL_STRONG_DRIVE: next_window = strong_drive_reg;
            `SEL_WAKE_SOURCE: next_window = wake_source_reg;
            `SEL_FUNC_LOW: next_window = function_select_low;
            `SEL_FUNC_HIGH: next_window = function_select_high;
            default: next_window = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_subreg_window <= 8'h00;
        end else begin
            port_subreg_window <= next_window;
        end
    end

    // ------------------------------------------------------------------
    // Pin muxing, one slice per pin
    // ------------------------------------------------------------------
    logic [7:0] next_out;
    logic [7:0] next_oe;
    genvar g;
    generate
        for (g = 0; g < `PORT_WIDTH; g++) begin : g_pin
            logic [1:0] fsel;
            logic drv_val;
            logic drv_en;
            // two select bits pick the function
            assign fsel = {function_select_high[g], function_select_low[g]};
            // alternate function owns the pin; otherwise GPIO
            assign drv_val = alt_function_enable_reg[g] ?
                alt_out[{3'(g), fsel}] : out_data[g];
            assign drv_en = alt_function_enable_reg[g] ?
                alt_oe[{3'(g), fsel}] : !pin_direction_bit[g];
            // open-drain drives only low, for both owners
            assign next_out[g] = open_drain_reg[g] ? 1'b0 : drv_val;
            assign next_oe[g] = open_drain_reg[g] ? (drv_en && !drv_val)
                                                  : drv_en;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pad registers; every pin-side output leaves a flip-flop
    // ------------------------------------------------------------------
    // drive value and enable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= 8'h00;
            pad_oe <= 8'h00;
        end else begin
            pad_out <= next_out;
            pad_oe <= next_oe;
        end
    end

    // strong drive per pin, any owner
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_strong <= 8'h00;
        end else begin
            pad_strong <= strong_drive_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_data <= 8'h00;
        end else begin
            in_data <= pad_sync;
        end
    end

    // pin value reaches only pins owned by a function
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_in <= 8'h00;
        end else begin
            alt_in <= pad_sync & alt_function_enable_reg;
        end
    end

    // ------------------------------------------------------------------
    // Stop-mode recovery
    // ------------------------------------------------------------------
    // either edge on an enabled pin; two synchronised samples differ
    logic [7:0] wake_edges;
    assign wake_edges = (pad_sync ^ pad_prev) & wake_source_reg;

    // Assumes core_clk runs in stop mode; a pin pulse shorter than a
    // clock period can slip between samples and wake nothing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_recovery <= 1'b0;
        end else begin
            stop_recovery <= stop_mode && (|wake_edges);
        end
    end

endmodule : gpio_pin_function_config

/* File: verification/pin_partner.sv */
/* Pin model for the far side of the port: resolves each pad.
   Assumes the bench drives the outside driver enables and values. */
`timescale 1ns/1ps
module pin_partner (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    // Undriven pads float high through a board pull-up, never hold
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
        (~pad_oe & ~ext_en);
endmodule : pin_partner

/* File: verification/gpio_pin_function_config_monitor.sv */
/* Assertions on the ports of the pin function block.
   Assumes a single core_clk domain and the bind at the foot. */
`timescale 1ns/1ps
module gpio_pin_function_config_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic select_wr,
    input wire logic window_wr,
    input wire logic [7:0] wr_data,
    input logic [7:0] port_subreg_select,
    input logic [7:0] port_subreg_window,
    input wire logic stop_mode,
    input wire logic [7:0] pad_in,
    input logic [7:0] pad_strong,
    input logic [7:0] in_data,
    input logic stop_recovery
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic live;
    logic strong_wr;
    assign live = window_wr && !select_wr &&
        port_subreg_select inside {[8'h02:8'h05]};
    assign strong_wr = window_wr && port_subreg_select == 8'h04;
    chk_select_load: assert property (select_wr |=>
        port_subreg_select == $past(wr_data)) else $error("select load");
    chk_select_hold: assert property (!select_wr |=>
        $stable(port_subreg_select)) else $error("select moved");
    chk_null_read: assert property ((port_subreg_select inside
        {8'h00, 8'h06} || port_subreg_select > 8'h08) |=>
        port_subreg_window == 8'h00) else $error("null select read");
    chk_window_read: assert property (live |-> ##2
        port_subreg_window == $past(wr_data, 2)) else $error("readback");
    chk_strong_write: assert property (strong_wr |-> ##2
        pad_strong == $past(wr_data, 2)) else $error("strong drive");
    chk_strong_hold: assert property ((!strong_wr)[*3] |->
        $stable(pad_strong)) else $error("strong drive moved");
    chk_input_sample: assert property (($stable(pad_in))[*8] |->
        in_data == pad_in) else $error("input sample");
    chk_wake_quiet: assert property (($stable(pad_in))[*6] |->
        !stop_recovery) else $error("wake without edge");
    chk_wake_idle: assert property ((!stop_mode)[*4] |->
        !stop_recovery) else $error("wake outside stop");
    chk_wake_pulse: assert property (stop_recovery |=>
        !stop_recovery) else $error("wake pulse too long");
    cover property (live);
    cover property (stop_recovery);
    cover property (window_wr && port_subreg_select == 8'h00);
endmodule : gpio_pin_function_config_monitor
bind gpio_pin_function_config gpio_pin_function_config_monitor u_monitor (
    .core_clk, .rst_b, .select_wr, .window_wr, .wr_data, .port_subreg_select,
    .port_subreg_window, .stop_mode, .pad_in, .pad_strong, .in_data,
    .stop_recovery);

/* File: verification/testbench.sv */
/* Self-checking bench for the pin function block.
   Assumes the pin model beside it and the monitor bound in. */
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic select_wr = 1'b0;
    logic window_wr = 1'b0;
    logic stop_mode = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] pin_direction_bit = 8'hff;
    logic [7:0] function_select_low = 8'h00;
    logic [7:0] function_select_high = 8'h00;
    logic [7:0] out_data = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [31:0] alt_out = 32'h0000_0000;
    logic [31:0] alt_oe = 32'h0000_0000;
    logic [7:0] port_subreg_select, port_subreg_window, pad_in, pad_out;
    logic [7:0] pad_oe, pad_strong, in_data, alt_in;
    logic stop_recovery;
    logic [7:0] window_d, window_small;
    int miscompares = 0;
    int comparisons = 0;
    always #2 core_clk = ~core_clk;
    gpio_pin_function_config u_gpio_pin_function_config (.core_clk, .rst_b,
        .select_wr, .window_wr, .wr_data, .port_subreg_select,
        .port_subreg_window, .pin_direction_bit, .function_select_low,
        .function_select_high, .out_data, .alt_out, .alt_oe, .stop_mode,
        .pad_in, .pad_out, .pad_oe, .pad_strong, .in_data, .alt_in,
        .stop_recovery);
    pin_partner u_pin_partner (.pad_out, .pad_oe, .ext_en, .ext_val, .pad_in);
    // Reset variants share the stimulus; only their windows are judged
    gpio_pin_function_config #(.VARIANT(gpio_pin_function_pkg::PORT_D))
        u_gpio_pin_function_config_d (.core_clk, .rst_b, .select_wr,
        .window_wr, .wr_data, .port_subreg_select(),
        .port_subreg_window(window_d), .pin_direction_bit,
        .function_select_low, .function_select_high, .out_data, .alt_out,
        .alt_oe, .stop_mode, .pad_in, .pad_out(), .pad_oe(), .pad_strong(),
        .in_data(), .alt_in(), .stop_recovery());
    gpio_pin_function_config #(.VARIANT(gpio_pin_function_pkg::PORT_A_SMALL))
        u_gpio_pin_function_config_small (.core_clk, .rst_b, .select_wr,
        .window_wr, .wr_data, .port_subreg_select(),
        .port_subreg_window(window_small), .pin_direction_bit,
        .function_select_low, .function_select_high, .out_data, .alt_out,
        .alt_oe, .stop_mode, .pad_in, .pad_out(), .pad_oe(), .pad_strong(),
        .in_data(), .alt_in(), .stop_recovery());
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Select then window on back-to-back edges
    task automatic put(input logic [7:0] sel, input logic [7:0] data);
        select_wr = 1'b1;
        wr_data = sel;
        tick(1);
        select_wr = 1'b0;
        window_wr = 1'b1;
        wr_data = data;
        tick(1);
        window_wr = 1'b0;
    endtask : put
    task automatic rd(input logic [7:0] sel, input logic [7:0] exp);
        select_wr = 1'b1;
        wr_data = sel;
        tick(1);
        select_wr = 1'b0;
        tick(2);
        chk(port_subreg_window, exp);
    endtask : rd
    task automatic test_done;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        chk(port_subreg_select, 8'h00);
        for (logic [7:0] k = 8'h02; k <= 8'h05; k++) rd(k, 8'h00);
        rd(8'h02, 8'h00);
        chk(window_d, 8'h01);
        chk(window_small, 8'h04);
        rd(8'h03, 8'h00);
        chk(window_d, 8'h01);
        chk(window_small, 8'h00);
        put(8'h00, 8'hff);
        put(8'h06, 8'hff);
        rd(8'h02, 8'h00);
        rd(8'h0a, 8'h00);
        for (logic [7:0] k = 8'h02; k <= 8'h05; k++)
            put(k, {k[3:0], ~k[3:0]});
        for (logic [7:0] k = 8'h02; k <= 8'h05; k++)
            rd(k, {k[3:0], ~k[3:0]});
        chk(pad_strong, 8'h4b);
    endtask : t_regs
    task automatic t_gpio;
        pin_direction_bit = 8'hf0;
        out_data = 8'h5a;
        ext_en = 8'hf0;
        ext_val = 8'h30;
        put(8'h02, 8'h00);
        put(8'h03, 8'h03);
        tick(12);
        chk(pad_oe, 8'h0d);
        chk(pad_out & pad_oe, 8'h08);
        chk(in_data, 8'h3a);
        rd(8'h01, 8'hf0);
    endtask : t_gpio
    task automatic t_alt;
        pin_direction_bit = 8'hff;
        ext_en = 8'h00;
        put(8'h03, 8'h00);
        put(8'h02, 8'h20); // pin 5 has functions behind it
        for (int s = 0; s < 4; s++) begin
            function_select_low[5] = s[0];
            function_select_high[5] = s[1];
            alt_out = 32'h0000_0001 << (20 + s);
            alt_oe = alt_out;
            tick(4);
            chk(pad_oe, 8'h20);
            chk(pad_out & pad_oe, 8'h20);
        end
        rd(8'h07, 8'h20);
        rd(8'h08, 8'h20);
        put(8'h03, 8'h20);
        tick(12);
        chk(pad_oe, 8'h00);
        chk(alt_in, 8'h20);
    endtask : t_alt
    task automatic t_wake;
        int n;
        put(8'h02, 8'h00);
        ext_en = 8'hff;
        put(8'h05, 8'h04);
        stop_mode = 1'b1;
        tick(8);
        for (int p = 0; p < 2; p++) begin
            n = 0;
            ext_val = p == 0 ? 8'h08 : 8'h0c;
            repeat (8) begin
                tick(1);
                if (stop_recovery === 1'b1) n++;
            end
            chk(8'(n), 8'(p));
        end
        stop_mode = 1'b0;
    endtask : t_wake
    initial begin
        tick(16);
        rst_b = 1'b1;
        tick(4);
        t_regs();
        t_gpio();
        t_alt();
        t_wake();
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #8000;
        miscompares++;
        test_done();
    end
endmodule : testbench
